// [logic/adcsq_consts.vh]
`ifndef ADCSQ_CONSTS_VH
`define ADCSQ_CONSTS_VH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ADCSQ_ADDR_CTRL 4'h0
`define ADCSQ_ADDR_RESH 4'h4
`define ADCSQ_ADDR_RESL 4'h8
`define ADCSQ_ADDR_W 4
// ----------------------------------------
// control field positions
// ----------------------------------------
`define ADCSQ_BIT_BUSY 0
`define ADCSQ_BIT_PSC 1
`define ADCSQ_BIT_MUX 2
`define ADCSQ_BIT_MODE 3
`define ADCSQ_CH_HI 7
`define ADCSQ_CH_LO 4
`define ADCSQ_CTRL_RST 8'h00
`define ADCSQ_RESL_MASK 8'hC0
// ----------------------------------------
// channel codes
// ----------------------------------------
`define ADCSQ_CH_MUXOUT 4'hE
`define ADCSQ_CH_ADIN 4'hF
// ----------------------------------------
// timing
// ----------------------------------------
`define ADCSQ_DIV_SLOW 5'h10
`define ADCSQ_DIV_FAST 5'h01
`define ADCSQ_PH_SAMPLE 4'h3
`define ADCSQ_PH_AZERO 4'h4
`define ADCSQ_PH_CONV 4'hE
`define ADCSQ_PH_LAST 4'hE
`define ADCSQ_PH_FIRST 4'h0
`define ADCSQ_PH_SMP_END 4'h2
`define ADCSQ_PH_CNV_END 4'hD
`define ADCSQ_RES_W 10
`endif

// [logic/adcsq_clkdiv.v]
`include "adcsq_consts.vh"
module adcsq_clkdiv (
  input wire clk_sys,
  input wire reset_n,
  input wire clkEn,
  input wire run,
  input wire divSel,
  output reg tick
);
  reg [4:0] cnt_reg;
  wire [4:0] lim = divSel ? `ADCSQ_DIV_SLOW : `ADCSQ_DIV_FAST;
  // ----------------------------------------
  // prescaler, held off while idle
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_reg <= 5'h00;
      tick <= 1'b0;
    end else if (clkEn) begin
      if (!run) begin
        cnt_reg <= 5'h00;
        tick <= 1'b0;
      end else if (cnt_reg + 5'h01 >= lim) begin
        cnt_reg <= 5'h00;
        tick <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
        tick <= 1'b0;
      end
    end
  end
endmodule

// [logic/adcsq_top.v]
`include "adcsq_consts.vh"
module adcsq_top (
  input wire clk_sys,
  input wire reset_n,
  input wire clkEn,
  input wire [`ADCSQ_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [`ADCSQ_RES_W-1:0] sarResult,
  output reg [3:0] chanSelPos,
  output reg [3:0] chanSelNeg,
  output reg diffMode,
  output reg chanEnable,
  output reg muxOutToPin14,
  output reg adInFromPin15,
  output reg convPowered,
  output reg convClkTick,
  output reg sampleOn,
  output reg autoZeroOn,
  output reg convertOn,
  output reg loadOn
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RUN = 4'b0010;
  localparam [3:0] ST_LOAD = 4'b0100;
  localparam [3:0] ST_ACK = 4'b1000;

  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  reg [7:0] resHigh_reg;
  reg [7:0] resLow_reg;
  reg [3:0] state_reg;
  reg [3:0] phase_reg;
  reg [`ADCSQ_RES_W-1:0] sarSync1_reg;
  reg [`ADCSQ_RES_W-1:0] sarSync2_reg;

  // ----------------------------------------
  // write strobe decode for one register
  // ----------------------------------------
  function wrHit;
    input [3:0] st;
    input wr;
    input [`ADCSQ_ADDR_W-1:0] addr;
    input be0;
    input [`ADCSQ_ADDR_W-1:0] target;
    begin
      wrHit = (st == ST_ACK) && wr && be0 && (addr == target);
    end
  endfunction

  // ----------------------------------------
  // read data for one address
  // ----------------------------------------
  function [31:0] readMux;
    input [`ADCSQ_ADDR_W-1:0] addr;
    input [7:0] ctrl;
    input [7:0] resH;
    input [7:0] resL;
    begin
      case (addr)
        `ADCSQ_ADDR_CTRL: readMux = {24'h00_0000, ctrl};
        `ADCSQ_ADDR_RESH: readMux = {24'h00_0000, resH};
        `ADCSQ_ADDR_RESL: readMux = {24'h00_0000, resL & `ADCSQ_RESL_MASK};
        default: readMux = 32'h0000_0000;
      endcase
    end
  endfunction

  // ----------------------------------------
  // phase window test
  // ----------------------------------------
  function inPhase;
    input [3:0] ph;
    input [3:0] lo;
    input [3:0] hi;
    begin
      inPhase = (ph >= lo) && (ph <= hi);
    end
  endfunction

  // ----------------------------------------
  // next converter phase, wraps after load
  // ----------------------------------------
  function [3:0] nextPhase;
    input [3:0] ph;
    begin
      if (ph == `ADCSQ_PH_LAST) begin
        nextPhase = `ADCSQ_PH_FIRST;
      end else begin
        nextPhase = ph + 4'h1;
      end
    end
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire tick;
  wire busy = ctrl_reg[`ADCSQ_BIT_BUSY];
  wire [3:0] chan = ctrl_reg[`ADCSQ_CH_HI:`ADCSQ_CH_LO];
  wire req = avs_read | avs_write;
  wire wrCtrl = wrHit(state_reg, avs_write, avs_address, avs_byteenable[0], `ADCSQ_ADDR_CTRL);
  wire wrResH = wrHit(state_reg, avs_write, avs_address, avs_byteenable[0], `ADCSQ_ADDR_RESH);
  wire wrResL = wrHit(state_reg, avs_write, avs_address, avs_byteenable[0], `ADCSQ_ADDR_RESL);
  wire startEdge = wrCtrl && !busy && avs_writedata[`ADCSQ_BIT_BUSY];
  wire done = busy && tick && (phase_reg == `ADCSQ_PH_LAST);

  // ----------------------------------------
  // partner of a channel in a pair
  // ----------------------------------------
  function [3:0] pairOf;
    input [3:0] c;
    begin
      pairOf = {c[3:1], ~c[0]};
    end
  endfunction

  adcsq_clkdiv u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .run(busy),
    .divSel(ctrl_reg[`ADCSQ_BIT_PSC]),
    .tick(tick)
  );

  // ----------------------------------------
  // bus slave: one wait cycle then answer
  // ----------------------------------------
  reg [3:0] bus_reg;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      bus_reg <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clkEn) begin
      case (bus_reg)
        ST_IDLE: begin
          avs_waitrequest <= 1'b1;
          if (req) begin
            bus_reg <= ST_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata <= readMux(avs_address, ctrl_reg, resHigh_reg, resLow_reg);
          end
        end
        ST_ACK: begin
          bus_reg <= ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_reg <= ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end
  always @* state_reg = bus_reg;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always @* begin
    ctrl_next = ctrl_reg;
    if (done) ctrl_next[`ADCSQ_BIT_BUSY] = 1'b0;
    if (wrCtrl) begin
      if (busy) begin
        ctrl_next[`ADCSQ_BIT_BUSY] = avs_writedata[`ADCSQ_BIT_BUSY];
      end else begin
        ctrl_next = avs_writedata[7:0];
      end
    end
  end
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_reg <= `ADCSQ_CTRL_RST;
    end else if (clkEn) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      phase_reg <= `ADCSQ_PH_FIRST;
    end else if (clkEn) begin
      if (!busy || startEdge) begin
        phase_reg <= `ADCSQ_PH_FIRST;
      end else if (tick) begin
        phase_reg <= nextPhase(phase_reg);
      end
    end
  end

  // ----------------------------------------
  // result input synchroniser
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (clkEn) begin
      sarSync1_reg <= sarResult;
      sarSync2_reg <= sarSync1_reg;
    end
  end

  // ----------------------------------------
  // result capture, no reset on data
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (clkEn) begin
      if (done) begin
        resHigh_reg <= sarSync2_reg[9:2];
        resLow_reg <= {sarSync2_reg[1:0], 6'h00};
      end else begin
        if (wrResH) resHigh_reg <= avs_writedata[7:0];
        if (wrResL) resLow_reg <= avs_writedata[7:0] & `ADCSQ_RESL_MASK;
      end
    end
  end

  // ----------------------------------------
  // analog steering outputs
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      chanSelPos <= 4'h0;
      chanSelNeg <= 4'h0;
      diffMode <= 1'b0;
      chanEnable <= 1'b0;
      muxOutToPin14 <= 1'b0;
      adInFromPin15 <= 1'b0;
      convPowered <= 1'b0;
      convClkTick <= 1'b0;
    end else if (clkEn) begin
      chanSelPos <= chan;
      chanSelNeg <= pairOf(chan);
      diffMode <= ctrl_reg[`ADCSQ_BIT_MODE];
      chanEnable <= busy | ctrl_reg[`ADCSQ_BIT_MUX];
      muxOutToPin14 <= ctrl_reg[`ADCSQ_BIT_MUX];
      adInFromPin15 <= ctrl_reg[`ADCSQ_BIT_MUX];
      convPowered <= busy;
      convClkTick <= tick && busy;
    end
  end

  // ----------------------------------------
  // converter phase levels
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      sampleOn <= 1'b0;
      autoZeroOn <= 1'b0;
      convertOn <= 1'b0;
      loadOn <= 1'b0;
    end else if (clkEn) begin
      sampleOn <= busy && inPhase(phase_reg, `ADCSQ_PH_FIRST, `ADCSQ_PH_SMP_END);
      autoZeroOn <= busy && inPhase(phase_reg, `ADCSQ_PH_SAMPLE, `ADCSQ_PH_SAMPLE);
      convertOn <= busy && inPhase(phase_reg, `ADCSQ_PH_AZERO, `ADCSQ_PH_CNV_END);
      loadOn <= busy && inPhase(phase_reg, `ADCSQ_PH_CONV, `ADCSQ_PH_LAST);
    end
  end
endmodule

// [tb/adcsq_top_props.sv]
module adcsq_top_props (
  input logic clk_sys,
  input logic reset_n,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic [3:0] chanSelPos,
  input logic [3:0] chanSelNeg,
  input logic diffMode,
  input logic chanEnable,
  input logic muxOutToPin14,
  input logic adInFromPin15,
  input logic convPowered,
  input logic convClkTick,
  input logic sampleOn,
  input logic autoZeroOn,
  input logic convertOn,
  input logic loadOn
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence sFirstSample;
    ##[1:17] sampleOn;
  endsequence
  sequence sPowerOff;
    ##[0:17] !convPowered;
  endsequence
  mux_pins_a: assert property (muxOutToPin14 == adInFromPin15) else $error("mux pins differ");
  mux_idle_a: assert property (muxOutToPin14 |-> chanEnable) else $error("channel off");
  diff_pair_a: assert property (diffMode && chanSelPos < 4'hc |-> chanSelNeg == (chanSelPos ^ 4'h1))
    else $error("bad pair");
  wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("long answer");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
    else $error("no answer");
  clock_gate_a: assert property (!convPowered && $past(!convPowered) |-> !convClkTick) else $error("tick idle");
  start_sample_a: assert property ($rose(convPowered) |-> sFirstSample) else $error("no sample");
  zero_order_a: assert property ($rose(autoZeroOn) |-> $past(sampleOn)) else $error("zero order");
  conv_order_a: assert property ($rose(convertOn) |-> $past(autoZeroOn)) else $error("conv order");
  load_done_a: assert property ($rose(loadOn) |-> sPowerOff) else $error("busy stuck");
endmodule
bind adcsq_top adcsq_top_props i_props (.*);

// [tb/adcsq_top_bench.sv]
`include "adcsq_consts.vh"
module adcsq_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset_n, clkEn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable, chanSelPos, chanSelNeg;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [9:0] sarResult;
  logic diffMode, chanEnable, muxOutToPin14, adInFromPin15, convPowered, convClkTick;
  logic sampleOn, autoZeroOn, convertOn, loadOn;
  int err_total, checked, cyc, ticks, t0, c0;
  `define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
  adcsq_top i_dut (.*);
  // ----------------------------------------
  // clock, timeout, tick count
  // ----------------------------------------
  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (convClkTick) ticks <= ticks + 1;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // bus access
  // ----------------------------------------
  task automatic acc(input bit w, input [3:0] a, input [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic waitIdle;
    rd = 32'h0000_0001;
    while (rd[0]) acc(0, `ADCSQ_ADDR_CTRL, 8'h00);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    reset_n = 0;
    clkEn = 1;
    avs_read = 0;
    avs_write = 0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    sarResult = 10'h2d6;
    cyc = 0;
    ticks = 0;
    err_total = 0;
    checked = 0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1;
    acc(0, `ADCSQ_ADDR_CTRL, 8'h00);
    `CHK(rd, 32'h0000_0000)
    acc(0, 4'hc, 8'h00);
    `CHK(rd, 32'h0000_0000)
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      acc(1, `ADCSQ_ADDR_CTRL, {i[3:0], 4'hc});
      settle;
      `CHK({chanSelPos, chanSelNeg}, {i[3:0], i[3:0] ^ 4'h1})
      `CHK({muxOutToPin14, adInFromPin15, chanEnable, convPowered, diffMode}, 5'b11101)
      acc(0, `ADCSQ_ADDR_CTRL, 8'h00);
      `CHK(rd[7:0], {i[3:0], 4'hc})
    end
    acc(1, `ADCSQ_ADDR_CTRL, 8'h50);
    settle;
    `CHK({diffMode, chanEnable, muxOutToPin14}, 3'b000)
    $display("select test done");
    acc(1, `ADCSQ_ADDR_CTRL, 8'h74);
    settle;
    `CHK({chanEnable, convPowered}, 2'b10)
    t0 = ticks;
    acc(1, `ADCSQ_ADDR_CTRL, 8'h75);
    acc(1, `ADCSQ_ADDR_CTRL, 8'h31);
    acc(0, `ADCSQ_ADDR_CTRL, 8'h00);
    `CHK(rd[7:0], 8'h75)
    waitIdle;
    `CHK(ticks - t0, 15)
    acc(0, `ADCSQ_ADDR_RESH, 8'h00);
    `CHK(rd, 32'h0000_00b5)
    acc(0, `ADCSQ_ADDR_RESL, 8'h00);
    `CHK(rd, 32'h0000_0080)
    $display("fast test done");
    acc(1, `ADCSQ_ADDR_RESH, 8'ha5);
    acc(1, `ADCSQ_ADDR_RESL, 8'hff);
    acc(0, `ADCSQ_ADDR_RESH, 8'h00);
    `CHK(rd[7:0], 8'ha5)
    acc(0, `ADCSQ_ADDR_RESL, 8'h00);
    `CHK(rd[7:0], 8'hc0)
    sarResult = 10'h13b;
    t0 = ticks;
    c0 = cyc;
    acc(1, `ADCSQ_ADDR_CTRL, 8'h03);
    waitIdle;
    `CHK(ticks - t0, 15)
    `CHK((cyc - c0) inside {[240:262]}, 1'b1)
    acc(0, `ADCSQ_ADDR_RESH, 8'h00);
    `CHK(rd[7:0], 8'h4e)
    $display("slow test done");
    acc(1, `ADCSQ_ADDR_CTRL, 8'h01);
    acc(1, `ADCSQ_ADDR_CTRL, 8'h00);
    settle;
    t0 = ticks;
    repeat (5) @(posedge clk_sys);
    `CHK({convPowered, ticks - t0}, 33'h0_0000_0000)
    acc(1, `ADCSQ_ADDR_CTRL, 8'h01);
    waitIdle;
    `CHK(ticks - t0, 15)
    $display("restart test done");
    tally_and_finish;
  end
endmodule
